// ===== eac_access_ctrl.sv
// nvm access control: io registers, arm/start handshake, cpu halts
`timescale 1ns/10ps
module eac_access_ctrl #(
  parameter logic [eac_pkg::TICK_W-1:0] ATOMIC_TICKS = eac_pkg::ATOMIC_TICKS,
  parameter logic [eac_pkg::TICK_W-1:0] SPLIT_TICKS  = eac_pkg::SPLIT_TICKS
) (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic [5:0]                  io_addr,
  input  wire logic                        io_wr,
  input  wire logic                        io_rd,
  input  wire logic [7:0]                  io_wdata,
  output logic      [7:0]                  io_rdata,
  output logic                             cpu_halt,
  output logic                             ready_irq,
  output logic                             flash_prog_block,
  output logic      [eac_pkg::ADDR_W-1:0]  arr_addr,
  output logic      [7:0]                  arr_wdata,
  output logic      [1:0]                  arr_mode,
  output logic                             arr_start,
  input  wire logic [7:0]                  arr_rdata
);
  typedef struct packed {
    logic [1:0]                  mode;
    logic                        rie;
    logic [2:0]                  mpe_cnt;
    logic [eac_pkg::ADDR_W-1:0]  addr;
    logic [7:0]                  data;
    logic [7:0]                  scr0;
    logic [7:0]                  scr1;
    logic [2:0]                  halt_cnt;
    logic                        start;
    logic [7:0]                  rdata;
  } eac_ctl_reg_t;

  eac_ctl_reg_t q;
  eac_ctl_reg_t d;
  eac_tmr_if    tif ();

  logic         busy;
  logic         accept;
  logic [7:0]   ctl_view;

  eac_prog_timer u_timer (
    .mclk (mclk),
    .rstn (rstn),
    .tif  (tif.tmr)
  );

  function automatic logic wr_hit(input logic [5:0] a, input logic [5:0] off,
                                  input logic we);
    wr_hit = we && (a == off);
  endfunction

  assign busy = tif.busy;

  // armed window is the counter being nonzero
  assign accept = rstn && wr_hit(io_addr, eac_pkg::NVM_CONTROL_OFF, io_wr)
                  && io_wdata[eac_pkg::CTL_PE] && (q.mpe_cnt != 3'h0)
                  && !busy && (q.mode != eac_pkg::MODE_RSVD); // RULE10 RULE11 RULE20

  assign tif.start = accept;
  assign tif.ticks = (q.mode == eac_pkg::MODE_ATOMIC) ? ATOMIC_TICKS
                                                      : SPLIT_TICKS; // RULE6

  always_comb begin
    ctl_view = 8'h00; // RULE5
    ctl_view[eac_pkg::CTL_MODE_HI:eac_pkg::CTL_MODE_LO] = q.mode;
    ctl_view[eac_pkg::CTL_RIE] = q.rie;
    ctl_view[eac_pkg::CTL_MPE] = (q.mpe_cnt != 3'h0);
    ctl_view[eac_pkg::CTL_PE]  = busy;
  end

  always_comb begin
    d = q;
    d.start = 1'b0;
    if (q.mpe_cnt != 3'h0) begin
      d.mpe_cnt = q.mpe_cnt - 3'h1; // RULE10
    end
    if (q.halt_cnt != 3'h0) begin
      d.halt_cnt = q.halt_cnt - 3'h1;
    end
    if (wr_hit(io_addr, eac_pkg::NVM_CONTROL_OFF, io_wr)) begin
      // the accepting write keeps the mode the timer was loaded with
      if (!busy && !accept) begin
        d.mode = io_wdata[eac_pkg::CTL_MODE_HI:eac_pkg::CTL_MODE_LO]; // RULE7
      end
      d.rie = io_wdata[eac_pkg::CTL_RIE]; // RULE9
      if (io_wdata[eac_pkg::CTL_MPE]) begin
        d.mpe_cnt = eac_pkg::MPE_WINDOW; // RULE10
      end
      if (accept) begin
        d.start    = 1'b1; // RULE12
        d.halt_cnt = eac_pkg::PROG_HALT; // RULE12
        d.mpe_cnt  = 3'h0;
      end else if (io_wdata[eac_pkg::CTL_RE] && !busy) begin
        // array read is combinational, so the byte lands at once
        d.data     = arr_rdata; // RULE15 RULE4
        d.halt_cnt = eac_pkg::READ_HALT; // RULE15
      end
    end
    // address frozen while the array is being programmed
    if (wr_hit(io_addr, eac_pkg::NVM_ADDRESS_OFF, io_wr) && !busy) begin // RULE16
      d.addr = io_wdata[eac_pkg::ADDR_W-1:0]; // RULE1 RULE3
    end
    if (wr_hit(io_addr, eac_pkg::NVM_DATA_OFF, io_wr) && !busy) begin
      d.data = io_wdata; // RULE4
    end
    if (wr_hit(io_addr, eac_pkg::SCRATCH_ZERO_OFF, io_wr)) begin
      d.scr0 = io_wdata; // RULE19
    end
    if (wr_hit(io_addr, eac_pkg::SCRATCH_ONE_OFF, io_wr)) begin
      d.scr1 = io_wdata; // RULE19
    end
    if (io_rd) begin
      case (io_addr)
        eac_pkg::SCRATCH_ZERO_OFF: d.rdata = q.scr0;
        eac_pkg::SCRATCH_ONE_OFF:  d.rdata = q.scr1;
        eac_pkg::NVM_CONTROL_OFF:  d.rdata = ctl_view;
        eac_pkg::NVM_DATA_OFF:     d.rdata = q.data;
        eac_pkg::NVM_ADDRESS_OFF:  d.rdata = {1'b0, q.addr}; // RULE1
        default:                   d.rdata = 8'h00;
      endcase
    end
    if (!rstn) begin
      d.rie      = 1'b0; // RULE24
      d.mpe_cnt  = 3'h0; // RULE24
      d.halt_cnt = 3'h0;
      d.start    = 1'b0;
      d.scr0     = eac_pkg::SCRATCH_RESET; // RULE19
      d.scr1     = eac_pkg::SCRATCH_RESET; // RULE19
      d.rdata    = 8'h00;
      // address, data and mode must hold for an operation still running
      if (!busy) begin
        d.mode = eac_pkg::MODE_RESET; // RULE8 RULE24
        d.addr = '0;
        d.data = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign io_rdata         = q.rdata;
  assign cpu_halt         = (q.halt_cnt != 3'h0); // RULE12 RULE15
  assign ready_irq        = q.rie && !busy; // RULE23 RULE9
  assign flash_prog_block = busy; // RULE14
  assign arr_addr         = q.addr;
  assign arr_wdata        = q.data; // RULE4
  assign arr_mode         = q.mode; // RULE6
  assign arr_start        = q.start;
endmodule // eac_access_ctrl

// ===== eac_asserts.sv
// port assertions for the nvm access control block
`timescale 1ns/10ps
module eac_asserts (
  input wire logic                       mclk,
  input wire logic                       rstn,
  input wire logic [5:0]                 io_addr,
  input wire logic                       io_wr,
  input wire logic [7:0]                 io_wdata,
  input wire logic                       cpu_halt,
  input wire logic                       ready_irq,
  input wire logic                       flash_prog_block,
  input wire logic [eac_pkg::ADDR_W-1:0] arr_addr,
  input wire logic [1:0]                 arr_mode,
  input wire logic                       arr_start
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire ctl_wr = io_wr && io_addr == eac_pkg::NVM_CONTROL_OFF;
  sequence s_halt2; cpu_halt ##1 cpu_halt ##1 !cpu_halt; endsequence
  sequence s_halt4; cpu_halt [*4] ##1 !cpu_halt; endsequence
  a_prog_halt_two: assert property (arr_start |-> s_halt2)
    else $error("program halt length wrong");
  // strobe with bit 1 is left out: an armed program strobe wins
  a_read_halt_four: assert property (ctl_wr && io_wdata[0] && !io_wdata[1]
    && !flash_prog_block |=> s_halt4) else $error("read halt length wrong");
  a_start_one_pulse: assert property (arr_start |=> !arr_start)
    else $error("start pulse too long");
  a_start_sets_busy: assert property (arr_start |-> flash_prog_block)
    else $error("start without busy");
  a_irq_not_busy: assert property (flash_prog_block |-> !ready_irq)
    else $error("ready request while busy");
  a_start_cause: assert property (arr_start
    |-> $past(ctl_wr) && $past(io_wdata[1])) else $error("start without strobe write");
  a_no_rsvd_start: assert property (arr_start |-> arr_mode != eac_pkg::MODE_RSVD)
    else $error("start in reserved mode");
  a_addr_held_busy: assert property ($past(flash_prog_block) && flash_prog_block
    |-> $stable(arr_addr)) else $error("address moved while busy");
  a_mode_held_busy: assert property ($past(flash_prog_block) && flash_prog_block
    |-> $stable(arr_mode)) else $error("mode moved while busy");
endmodule // eac_asserts
bind eac_access_ctrl eac_asserts u_asserts (.mclk(mclk), .rstn(rstn), .io_addr(io_addr),
  .io_wr(io_wr), .io_wdata(io_wdata), .cpu_halt(cpu_halt), .ready_irq(ready_irq),
  .flash_prog_block(flash_prog_block), .arr_addr(arr_addr), .arr_mode(arr_mode),
  .arr_start(arr_start));

// ===== eac_pkg.sv
// constants and types for the nvm access control block
// Functional notes
// RULE1 - address is eight bits, bit 7 reads zero
// RULE2 - software loads address before any access
// RULE3 - bytes addressed linearly across 128 locations
// RULE4 - data register feeds writes, catches read bytes
// RULE5 - control bits 7 and 6 read zero
// RULE6 - mode field selects atomic, erase or write
// RULE7 - mode writes ignored while program enable set
// RULE8 - reset clears mode unless programming runs
// RULE9 - ready interrupt enable gates ready request
// RULE10 - strobe within four cycles after master enable
// RULE11 - strobe without master enable does nothing
// RULE12 - accepted strobe halts cpu two cycles
// RULE13 - program enable clears after programming time
// RULE14 - block flash, fuse, lock programming while busy
// RULE15 - read strobe fetches byte, halts four cycles
// RULE16 - while busy refuse reads and address writes
// RULE17 - started programming survives a reset
// RULE18 - software follows wait, setup, arm, strobe order
// RULE19 - two scratch registers, plain, reset zero
// RULE20 - reject other memory operations while busy
// RULE21 - time programming from 8 MHz oscillator
// RULE22 - software erases before write only
// RULE23 - ready request is a level
// RULE24 - enables reset zero, busy state kept
package eac_pkg;
  localparam logic [5:0]  SCRATCH_ZERO_OFF = 6'h13;
  localparam logic [5:0]  SCRATCH_ONE_OFF  = 6'h14;
  localparam logic [5:0]  NVM_CONTROL_OFF  = 6'h1C;
  localparam logic [5:0]  NVM_DATA_OFF     = 6'h1D;
  localparam logic [5:0]  NVM_ADDRESS_OFF  = 6'h1E;

  localparam int          ADDR_W           = 7;
  localparam int          ARRAY_SIZE       = 128;
  localparam int          TICK_W           = 15;

  localparam int          CTL_MODE_HI      = 5;
  localparam int          CTL_MODE_LO      = 4;
  localparam int          CTL_RIE          = 3;
  localparam int          CTL_MPE          = 2;
  localparam int          CTL_PE           = 1;
  localparam int          CTL_RE           = 0;

  localparam logic [1:0]  MODE_ATOMIC      = 2'h0;
  localparam logic [1:0]  MODE_ERASE       = 2'h1;
  localparam logic [1:0]  MODE_WRITE       = 2'h2;
  localparam logic [1:0]  MODE_RSVD        = 2'h3;
  localparam logic [1:0]  MODE_RESET       = 2'h0;

  localparam logic [2:0]  MPE_WINDOW       = 3'h4;
  localparam logic [2:0]  PROG_HALT        = 3'h2;
  localparam logic [2:0]  READ_HALT        = 3'h4;
  localparam logic [7:0]  SCRATCH_RESET    = 8'h00;

  localparam int          CLK_HZ           = 100000000;
  localparam int          OSC_HZ           = 8000000;
  localparam int          ATOMIC_TIME_US   = 3400;
  localparam int          SPLIT_TIME_US    = 1800;
  localparam logic [TICK_W-1:0] ATOMIC_TICKS =
    TICK_W'(ATOMIC_TIME_US * (OSC_HZ / 1000000));
  localparam logic [TICK_W-1:0] SPLIT_TICKS  =
    TICK_W'(SPLIT_TIME_US * (OSC_HZ / 1000000));

  localparam int          ACC_W            = 7;
  localparam logic [ACC_W-1:0] ACC_STEP    = ACC_W'(OSC_HZ / 1000000);
  localparam logic [ACC_W-1:0] ACC_MOD     = ACC_W'(CLK_HZ / 1000000);

  typedef enum logic [1:0] {
    EAC_TMR_IDLE = 2'b01,
    EAC_TMR_RUN  = 2'b10
  } eac_tmr_state_t;
endpackage

// ===== eac_prog_timer.sv
// programming timer clocked by an 8 MHz enable derived from mclk
`timescale 1ns/10ps
module eac_prog_timer (
  input wire logic   mclk,
  input wire logic   rstn,
  eac_tmr_if.tmr     tif
);
  typedef struct packed {
    eac_pkg::eac_tmr_state_t      state;
    logic [eac_pkg::ACC_W-1:0]    acc;
    logic [eac_pkg::TICK_W-1:0]   cnt;
    logic                         done;
  } eac_tmr_reg_t;

  eac_tmr_reg_t q;
  eac_tmr_reg_t d;

  always_comb begin
    logic [eac_pkg::ACC_W:0] sum;
    logic                    tick;
    d    = q;
    sum  = {1'b0, q.acc} + {1'b0, eac_pkg::ACC_STEP};
    tick = 1'b0;
    d.done = 1'b0;
    // fractional divider: 8 ticks per 100 mclk cycles, no drift
    if (sum >= {1'b0, eac_pkg::ACC_MOD}) begin // RULE21
      d.acc = eac_pkg::ACC_W'(sum - {1'b0, eac_pkg::ACC_MOD});
      tick  = 1'b1;
    end else begin
      d.acc = eac_pkg::ACC_W'(sum);
    end
    case (q.state)
      eac_pkg::EAC_TMR_IDLE: begin
        if (tif.start) begin
          d.cnt   = tif.ticks;
          d.state = eac_pkg::EAC_TMR_RUN;
        end
      end
      eac_pkg::EAC_TMR_RUN: begin
        if (tick) begin
          if (q.cnt <= eac_pkg::TICK_W'(1)) begin // RULE13
            d.state = eac_pkg::EAC_TMR_IDLE;
            d.cnt   = '0;
            d.done  = 1'b1;
          end else begin
            d.cnt = q.cnt - eac_pkg::TICK_W'(1);
          end
        end
      end
      default: begin
        d.state = eac_pkg::EAC_TMR_IDLE;
      end
    endcase
    // a running operation ignores reset and finishes
    if (!rstn && q.state != eac_pkg::EAC_TMR_RUN) begin // RULE17
      d.state = eac_pkg::EAC_TMR_IDLE;
      d.acc   = '0;
      d.cnt   = '0;
      d.done  = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign tif.busy = (q.state == eac_pkg::EAC_TMR_RUN);
  assign tif.done = q.done;
endmodule // eac_prog_timer

// ===== eac_tmr_if.sv
// carrier between control logic and programming timer
`timescale 1ns/10ps
interface eac_tmr_if;
  logic                           start;
  logic [eac_pkg::TICK_W-1:0]     ticks;
  logic                           busy;
  logic                           done;
  modport ctrl (output start, output ticks, input busy, input done);
  modport tmr  (input start, input ticks, output busy, output done);
endinterface

// ===== test_eac_access_ctrl.sv
// self-checking bench for the nvm access control block
`timescale 1ns/10ps
module test_eac_access_ctrl;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic [5:0] io_addr = 6'h00;
  logic       io_wr = 1'b0;
  logic       io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata, arr_wdata, arr_rdata;
  logic [6:0] arr_addr;
  logic [1:0] arr_mode;
  logic       cpu_halt, ready_irq, flash_prog_block, arr_start;
  int         n_fail = 0;
  int         checks_done = 0;
  always #5 mclk = ~mclk;
  // array stand-in: byte follows address so a wrong address shows
  assign arr_rdata = {1'b1, arr_addr} ^ 8'h5A;
  eac_access_ctrl #(.ATOMIC_TICKS(15'h0003), .SPLIT_TICKS(15'h0002)) DUT (.mclk(mclk),
    .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .cpu_halt(cpu_halt), .ready_irq(ready_irq),
    .flash_prog_block(flash_prog_block), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_mode(arr_mode), .arr_start(arr_start), .arr_rdata(arr_rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic rst(input int k);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (k) @(posedge mclk);
    rstn <= 1'b1;
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge mclk);
    io_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge mclk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge mclk);
    io_rd <= 1'b0;
    #1 chk(io_rdata, exp);
  endtask
  task automatic t_regs;
    rd(6'h13, 8'h00);
    rd(6'h1C, 8'h00);
    wr(6'h13, 8'hA5);
    wr(6'h14, 8'h3C);
    wr(6'h00, 8'hFF);
    rd(6'h13, 8'hA5);
    rd(6'h14, 8'h3C);
    rd(6'h00, 8'h00);
    wr(6'h1C, 8'hF8);
    rd(6'h1C, 8'h38);
    chk({7'h00, ready_irq}, 8'h01);
    wr(6'h1C, 8'h00);
    chk({7'h00, ready_irq}, 8'h00);
    wr(6'h1E, 8'hFF);
    rd(6'h1E, 8'h7F);
  endtask
  task automatic t_read;
    wr(6'h1E, 8'h7F);
    wr(6'h1C, 8'h01);
    chk({7'h00, cpu_halt}, 8'h01);
    rd(6'h1D, 8'hA5);
    rd(6'h1C, 8'h00);
    chk({7'h00, cpu_halt}, 8'h00);
  endtask
  task automatic t_refused;
    wr(6'h1C, 8'h02);
    chk({7'h00, arr_start}, 8'h00);
    wr(6'h1C, 8'h04);
    repeat (5) @(posedge mclk);
    wr(6'h1C, 8'h02);
    chk({7'h00, arr_start}, 8'h00);
    // reserved mode, armed in time, must still not start
    wr(6'h1C, 8'h34);
    wr(6'h1C, 8'h32);
    chk({7'h00, arr_start}, 8'h00);
    // master enable still reads set in its fourth cycle, then clears
    rd(6'h1C, 8'h34);
    rd(6'h1C, 8'h30);
    wr(6'h1C, 8'h00);
  endtask
  task automatic t_prog(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
    int n;
    int t;
    t = (m == eac_pkg::MODE_ATOMIC) ? 3 : 2;
    wr(6'h1C, {2'h0, m, 4'h0});
    wr(6'h1E, a);
    wr(6'h1D, d);
    wr(6'h1C, {2'h0, m, 4'h4});
    wr(6'h1C, {2'h0, m, 4'h2});
    chk({7'h00, arr_start}, 8'h01);
    chk({7'h00, cpu_halt}, 8'h01);
    chk({1'b0, arr_addr}, {1'b0, a[6:0]});
    chk(arr_wdata, d);
    chk({6'h00, arr_mode}, {6'h00, m});
    wr(6'h1E, a ^ 8'h01);
    wr(6'h1C, {2'h0, ~m, 4'h9});
    chk({7'h00, ready_irq}, 8'h00);
    rd(6'h1C, {2'h0, m, 4'hA});
    n = 6;
    while (flash_prog_block !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      #1 n++;
    end
    // one oscillator tick is 12.5 mclk, so allow a tick of slack
    chk(8'(n >= (t - 1) * 12 && n <= (t + 1) * 13 + 2), 8'h01);
    chk({7'h00, ready_irq}, 8'h01);
    rd(6'h1E, {1'b0, a[6:0]});
    rd(6'h1C, {2'h0, m, 4'h8});
  endtask
  task automatic t_reset_busy;
    wr(6'h1C, 8'h14);
    wr(6'h1C, 8'h12);
    rst(2);
    chk({7'h00, flash_prog_block}, 8'h01);
    chk({6'h00, arr_mode}, 8'h01);
    repeat (60) @(posedge mclk);
    rd(6'h1C, 8'h10);
    rst(2);
    rd(6'h1C, 8'h00);
  endtask
  task automatic test_done;
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    test_done;
  end
  initial begin
    rst(5);
    t_regs;
    t_read;
    t_refused;
    t_prog(eac_pkg::MODE_ATOMIC, 8'h7F, 8'h5A);
    t_prog(eac_pkg::MODE_ERASE, 8'h00, 8'hFF);
    t_prog(eac_pkg::MODE_WRITE, 8'h00, 8'h3C);
    t_reset_busy;
    test_done;
  end
endmodule // test_eac_access_ctrl
